// file: pkg/crt_pkg.sv
package crt_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] OFS_RESULT_LOW   = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH  = 8'h01;
    localparam logic [7:0] OFS_TRIG_SELECT  = 8'h02;
    localparam logic [7:0] OFS_PIN_DISABLE  = 8'h03;
    localparam logic [7:0] OFS_CTRL_STAT_A  = 8'h04;
    localparam logic [7:0] OFS_CHANNEL_MUX  = 8'h05;

    // Values after reset
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [9:0] RST_RESULT       = 10'h000;

    // converter_control_status_a fields
    localparam int CA_ENABLE    = 7;
    localparam int CA_START     = 6;
    localparam int CA_AUTO      = 5;
    localparam int CA_FLAG      = 4;
    localparam int CA_IRQ_EN    = 3;
    localparam int CA_PRESC_LSB = 0;

    // channel_mux_control fields
    localparam int MUX_LEFT_ADJ = 5;
    localparam int MUX_CH_LSB   = 0;

    // conversion_trigger_select fields
    localparam int TS_CMP_MUX   = 6;
    localparam int TS_SRC_LSB   = 0;
    localparam logic [7:0] TS_READ_MASK = 8'h47;

    // Channel codes that select a differential pair
    localparam logic [4:0] DIFF_FIRST = 5'h08;
    localparam logic [4:0] DIFF_LAST  = 5'h1d;

    typedef enum logic [2:0] {
        SRC_FREE_RUN,
        SRC_COMPARATOR,
        SRC_EXT_IRQ0,
        SRC_T0_COMPARE,
        SRC_T0_OVERFLOW,
        SRC_T1_COMPARE_B,
        SRC_T1_OVERFLOW,
        SRC_T1_CAPTURE
    } crt_trig_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } crt_bus_req_t;

    typedef struct packed {
        logic       done;
        logic [9:0] value;
    } crt_core_res_t;

endpackage : crt_pkg

// file: rtl/crt_trig_edge.sv
`timescale 1ns/1ps

module crt_trig_edge (
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    // Selection
    input  wire crt_pkg::crt_trig_src_t i_src,
    input  wire logic                   i_auto_en,
    // Interrupt flags of the trigger sources, index = source code
    input  wire logic [7:1]             i_flags,
    // Rising edge of the selected flag
    output logic                        o_event
);

    logic level;
    logic prev_level;

    always_comb begin
        unique case (i_src)
            crt_pkg::SRC_FREE_RUN:     level = 1'b0;
            crt_pkg::SRC_COMPARATOR:   level = i_flags[1];
            crt_pkg::SRC_EXT_IRQ0:     level = i_flags[2];
            crt_pkg::SRC_T0_COMPARE:   level = i_flags[3];
            crt_pkg::SRC_T0_OVERFLOW:  level = i_flags[4];
            crt_pkg::SRC_T1_COMPARE_B: level = i_flags[5];
            crt_pkg::SRC_T1_OVERFLOW:  level = i_flags[6];
            crt_pkg::SRC_T1_CAPTURE:   level = i_flags[7];
        endcase
    end

    // Tracking the muxed level makes a switch to a set source look like an edge
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level;
        end
    end

    assign o_event = i_auto_en && level && !prev_level;

    a_no_auto_event:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_auto_en |-> !o_event)
        else $error("trigger event while auto trigger is off");

    a_free_run_quiet:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_src == crt_pkg::SRC_FREE_RUN) |-> !o_event)
        else $error("free running selection produced a trigger event");

endmodule : crt_trig_edge

// file: rtl/crt_result_trigger.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module crt_result_trigger (
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    // Register port
    input  wire crt_pkg::crt_bus_req_t  i_bus,
    output logic [7:0]                  o_rdata,
    // Converter core
    input  wire crt_pkg::crt_core_res_t i_core,
    output logic                        o_conv_start,
    output logic                        o_core_enable,
    output logic [4:0]                  o_channel_sel,
    output logic [2:0]                  o_prescale,
    // Trigger sources and flag handshake
    input  wire logic [7:1]             i_trig_flags,
    input  wire logic                   i_vector_ack,
    output logic                        o_complete_flag,
    output logic                        o_irq_enable,
    output logic                        o_cmp_mux_enable,
    // Analog pins
    input  wire logic [7:0]             i_port_pin,
    output logic [7:0]                  o_input_buffer_off,
    output logic [7:0]                  o_pin_in
);

    typedef enum logic {ST_IDLE, ST_CONV} crt_state_t;

    crt_state_t             state;
    crt_pkg::crt_trig_src_t trig_src;
    logic [7:0]             mux_ctrl;
    logic [7:0]             pin_disable;
    logic [9:0]             result;
    logic                   enable;
    logic                   auto_en;
    logic                   res_diff;
    logic                   lock;
    logic                   free_pend;
    logic                   trig_evt;
    logic [7:0]             next_rdata;
    logic                   next_enable;

    // Decoded strobes, plus the left_adj and ch_diff levels
    logic wr_ctrl;
    logic wr_mux;
    logic wr_trig;
    logic wr_pins;
    logic rd_low;
    logic rd_high;
    logic sw_start;
    logic start_now;
    logic done_acc;
    logic upd;
    logic left_adj;
    logic ch_diff;

    assign wr_ctrl  = i_bus.wr && (i_bus.addr == crt_pkg::OFS_CTRL_STAT_A);
    assign wr_mux   = i_bus.wr && (i_bus.addr == crt_pkg::OFS_CHANNEL_MUX);
    assign wr_trig  = i_bus.wr && (i_bus.addr == crt_pkg::OFS_TRIG_SELECT);
    assign wr_pins  = i_bus.wr && (i_bus.addr == crt_pkg::OFS_PIN_DISABLE);
    assign rd_low   = i_bus.rd && (i_bus.addr == crt_pkg::OFS_RESULT_LOW);
    assign rd_high  = i_bus.rd && (i_bus.addr == crt_pkg::OFS_RESULT_HIGH);
    assign left_adj = mux_ctrl[crt_pkg::MUX_LEFT_ADJ];

    assign ch_diff = (mux_ctrl[4:0] >= crt_pkg::DIFF_FIRST)
                  && (mux_ctrl[4:0] <= crt_pkg::DIFF_LAST);

    // Enable written in the same cycle as a start still counts
    assign next_enable = wr_ctrl ? i_bus.wdata[crt_pkg::CA_ENABLE] : enable;
    assign sw_start    = wr_ctrl && i_bus.wdata[crt_pkg::CA_START];

    // Starts are only taken while idle; a trigger during a conversion is dropped
    assign start_now = (state == ST_IDLE) && next_enable
                    && (sw_start || trig_evt || free_pend);

    assign done_acc = (state == ST_CONV) && enable && i_core.done;
    // A completion beside a low-byte read is dropped, else the pair would tear
    assign upd      = done_acc && !lock && !rd_low;

    crt_trig_edge u_trig_edge (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_src     (trig_src),
        .i_auto_en (auto_en),
        .i_flags   (i_trig_flags),
        .o_event   (trig_evt)
    );

    // Control register A
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            enable       <= 1'b0;
            auto_en      <= 1'b0;
            o_irq_enable <= 1'b0;
            o_prescale   <= 3'h0;
        end else if (wr_ctrl) begin
            enable       <= i_bus.wdata[crt_pkg::CA_ENABLE];
            auto_en      <= i_bus.wdata[crt_pkg::CA_AUTO];
            o_irq_enable <= i_bus.wdata[crt_pkg::CA_IRQ_EN];
            o_prescale   <= i_bus.wdata[crt_pkg::CA_PRESC_LSB +: 3];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_core_enable <= 1'b0;
        end else begin
            o_core_enable <= next_enable;
        end
    end

    // Channel mux and trigger select
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mux_ctrl <= crt_pkg::RST_BYTE;
        end else if (wr_mux) begin
            mux_ctrl <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            trig_src         <= crt_pkg::SRC_FREE_RUN;
            o_cmp_mux_enable <= 1'b0;
        end else if (wr_trig) begin
            trig_src         <= crt_pkg::crt_trig_src_t'(i_bus.wdata[crt_pkg::TS_SRC_LSB +: 3]);
            o_cmp_mux_enable <= i_bus.wdata[crt_pkg::TS_CMP_MUX];
        end
    end

    // Digital input disable
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pin_disable <= crt_pkg::RST_BYTE;
        end else if (wr_pins) begin
            pin_disable <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_input_buffer_off <= crt_pkg::RST_BYTE;
        end else begin
            o_input_buffer_off <= wr_pins ? i_bus.wdata : pin_disable;
        end
    end

    for (genvar gi = 0; gi < 8; gi++) begin : g_pin
        always_ff @(posedge i_ref_clk) begin
            if (i_sys_rst) begin
                o_pin_in[gi] <= 1'b0;
            end else begin
                o_pin_in[gi] <= i_port_pin[gi] && !pin_disable[gi];
            end
        end
    end

    // Conversion sequencing
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_now) begin
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (!enable || done_acc) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_conv_start  <= 1'b0;
            o_channel_sel <= 5'h00;
            res_diff      <= 1'b0;
        end else begin
            o_conv_start <= start_now;
            // Channel changes wait for the next conversion
            if (start_now) begin
                o_channel_sel <= mux_ctrl[4:0];
                res_diff      <= ch_diff;
            end
        end
    end

    // Free running restart is held one cycle so the core sees a clean gap
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            free_pend <= 1'b0;
        end else if (done_acc && auto_en && (trig_src == crt_pkg::SRC_FREE_RUN)) begin
            free_pend <= 1'b1;
        end else if (start_now || !auto_en || !enable) begin
            free_pend <= 1'b0;
        end
    end

    // Result store; a completion while locked is discarded
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            result <= crt_pkg::RST_RESULT;
        end else if (upd) begin
            if (res_diff) begin
                result <= {~i_core.value[9], i_core.value[8:0]};
            end else begin
                result <= i_core.value;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            lock <= 1'b0;
        end else if (rd_high) begin
            lock <= 1'b0;
        end else if (rd_low) begin
            lock <= 1'b1;
        end
    end

    // Completion flag: a completion in the clearing cycle wins
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_complete_flag <= 1'b0;
        end else if (upd) begin
            o_complete_flag <= 1'b1;
        end else if ((wr_ctrl && i_bus.wdata[crt_pkg::CA_FLAG]) || i_vector_ack) begin
            o_complete_flag <= 1'b0;
        end
    end

    // Read data
    always_comb begin
        next_rdata = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                crt_pkg::OFS_RESULT_LOW: begin
                    if (left_adj) begin
                        next_rdata = {result[1:0], 6'h00};
                    end else begin
                        next_rdata = result[7:0];
                    end
                end
                crt_pkg::OFS_RESULT_HIGH: begin
                    if (left_adj) begin
                        next_rdata = result[9:2];
                    end else begin
                        next_rdata = {6'h00, result[9:8]};
                    end
                end
                crt_pkg::OFS_TRIG_SELECT: begin
                    next_rdata = {1'b0, o_cmp_mux_enable, 3'h0, trig_src} 
                               & crt_pkg::TS_READ_MASK;
                end
                crt_pkg::OFS_PIN_DISABLE: begin
                    next_rdata = pin_disable;
                end
                crt_pkg::OFS_CTRL_STAT_A: begin
                    next_rdata = {enable, state == ST_CONV, auto_en,
                                  o_complete_flag, o_irq_enable, o_prescale};
                end
                crt_pkg::OFS_CHANNEL_MUX: begin
                    next_rdata = mux_ctrl;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    a_right_adjust_hi:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        rd_high && !left_adj
        |=> (o_rdata[7:2] == 6'h00) && (o_rdata[1:0] == $past(result[9:8])))
        else $error("right adjusted high byte wrong");

    a_left_adjust_lo:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        rd_low && left_adj
        |=> (o_rdata[5:0] == 6'h00) && (o_rdata[7:6] == $past(result[1:0])))
        else $error("left adjusted low byte wrong");

    a_diff_twos:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        upd && res_diff
        |=> result == {~$past(i_core.value[9]), $past(i_core.value[8:0])})
        else $error("differential result not two's complement");

    a_lock_holds:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (lock || rd_low) |=> $stable(result))
        else $error("result changed while locked");

    a_resv_zero:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_bus.rd && (i_bus.addr == crt_pkg::OFS_TRIG_SELECT)
        |=> (o_rdata & ~crt_pkg::TS_READ_MASK) == 8'h00)
        else $error("reserved trigger select bits read nonzero");

    a_edge_start:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        trig_evt && (state == ST_IDLE) && enable && !wr_ctrl
        |=> o_conv_start ##1 (state == ST_CONV || !enable))
        else $error("trigger edge did not start a conversion");

    a_pin_masked:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_pin_in & $past(pin_disable)) == 8'h00)
        else $error("disabled pin reads one");

    a_flag_on_update:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        upd |=> o_complete_flag && !lock && (result[8:0] == $past(i_core.value[8:0])))
        else $error("completion did not set the flag");

    a_abort_stop:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (state == ST_CONV) && !enable && !wr_ctrl |=> (state == ST_IDLE) && !o_core_enable)
        else $error("disable did not stop the conversion");

    a_free_restart:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        free_pend && (state == ST_IDLE) && enable && auto_en && !wr_ctrl
        |=> o_conv_start)
        else $error("free running did not restart");

endmodule : crt_result_trigger

// file: verification/crt_core_model.sv
`timescale 1ns/1ps

module crt_core_model #(
    parameter int DELAY = 5
) (
    // Clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    // Requests from the block
    input  wire logic                   i_start,
    input  wire logic                   i_enable,
    // Value to hand back at completion
    input  wire logic [9:0]             i_value,
    // Result towards the block
    output crt_pkg::crt_core_res_t      o_res
);
    int         cnt;
    logic       done_q;
    logic [9:0] val_q;

    // Value lines do not hold between results, so stale data cannot pass as a match
    assign o_res = '{done: done_q, value: done_q ? val_q : ~val_q};

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || !i_enable) begin
            cnt    <= 0;
            done_q <= 1'b0;
            if (i_sys_rst) begin
                val_q <= 10'h000;
            end
        end else begin
            done_q <= 1'b0;
            if (i_start) begin
                cnt <= DELAY;
            end else if (cnt == 1) begin
                cnt    <= 0;
                done_q <= 1'b1;
                val_q  <= i_value;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : crt_core_model

// file: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic                   i_ref_clk;
    logic                   i_sys_rst;
    crt_pkg::crt_bus_req_t  bus;
    crt_pkg::crt_core_res_t core;
    logic [7:0]             rdata, buf_off, pin_in, port_pin, rv;
    logic [4:0]             chan;
    logic [2:0]             presc;
    logic                   irq_en;
    logic [7:1]             trig;
    logic [9:0]             core_val;
    logic                   start, core_en, flag, vec_ack, cmp_en;
    int                     n_fail = 0;
    int                     tests_run = 0;
    int                     starts = 0;
    int                     n;

    crt_result_trigger dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
        .o_rdata(rdata), .i_core(core), .o_conv_start(start), .o_core_enable(core_en),
        .o_channel_sel(chan), .o_prescale(presc), .i_trig_flags(trig), .i_vector_ack(vec_ack),
        .o_complete_flag(flag), .o_irq_enable(irq_en), .o_cmp_mux_enable(cmp_en),
        .i_port_pin(port_pin), .o_input_buffer_off(buf_off), .o_pin_in(pin_in));

    crt_core_model #(.DELAY(5)) core_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_start(start), .i_enable(core_en), .i_value(core_val), .o_res(core));

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) if (start === 1'b1) starts++;

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check($sformatf("reg %h", a), {2'b00, d}, {2'b00, exp});
    endtask : rchk

    task automatic wait_done();
        int i;
        for (i = 0; i < 30 && core.done !== 1'b1; i++) cyc(1);
        check("done seen", 10'(i < 30), 10'h001);
        cyc(1);
    endtask : wait_done

    task automatic conv(input logic [9:0] v);
        core_val = v;
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'hc0);
        wait_done();
    endtask : conv

    task automatic t_reset();
        for (int a = 0; a < 6; a++) rchk(8'(a), crt_pkg::RST_BYTE);
        rchk(8'h09, 8'h00);
        wr(crt_pkg::OFS_TRIG_SELECT, 8'h47);
        rchk(crt_pkg::OFS_TRIG_SELECT, 8'h47);
        check("cmp mux", {9'h000, cmp_en}, 10'h001);
        wr(crt_pkg::OFS_TRIG_SELECT, 8'h00);
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'h0d);
        #1 check("irq prescale", {6'h00, irq_en, presc}, 10'h00d);
        rchk(crt_pkg::OFS_CTRL_STAT_A, 8'h0d);
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'h00);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_result();
        conv(10'h2a5);
        check("flag set", {9'h000, flag}, 10'h001);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'ha5);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h02);
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'h90);
        cyc(1);
        check("flag w1c", {9'h000, flag}, 10'h000);
        conv(10'h155);
        @(posedge i_ref_clk) vec_ack <= 1'b1;
        @(posedge i_ref_clk) vec_ack <= 1'b0;
        #1 check("flag vector", {9'h000, flag}, 10'h000);
        $display("test result finished");
    endtask : t_result

    task automatic t_lock();
        conv(10'h2a5);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'ha5);
        conv(10'h15a);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h02);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'ha5);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h02);
        conv(10'h15a);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'h5a);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h01);
        $display("test lock finished");
    endtask : t_lock

    task automatic t_left();
        wr(crt_pkg::OFS_CHANNEL_MUX, 8'h20);
        conv(10'h2a5);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'h40);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'ha9);
        conv(10'h3ff);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'hff);
        conv(10'h001);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h00);
        wr(crt_pkg::OFS_CHANNEL_MUX, 8'h08);
        conv(10'h005);
        check("channel", {5'h00, chan}, 10'h008);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'h05);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h02);
        conv(10'h3f0);
        rchk(crt_pkg::OFS_RESULT_LOW, 8'hf0);
        rchk(crt_pkg::OFS_RESULT_HIGH, 8'h01);
        wr(crt_pkg::OFS_CHANNEL_MUX, 8'h00);
        $display("test adjust finished");
    endtask : t_left

    task automatic t_trig();
        for (int s = 1; s < 8; s++) begin
            wr(crt_pkg::OFS_TRIG_SELECT, 8'(s));
            wr(crt_pkg::OFS_CTRL_STAT_A, 8'ha0);
            n = starts;
            @(posedge i_ref_clk) trig[s] <= 1'b1;
            cyc(4);
            check($sformatf("start src %0d", s), 10'(starts - n), 10'h001);
            wait_done();
            @(posedge i_ref_clk) trig <= '0;
        end
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'h80);
        wr(crt_pkg::OFS_TRIG_SELECT, 8'h01);
        n = starts;
        @(posedge i_ref_clk) trig[1] <= 1'b1;
        cyc(4);
        check("auto off", 10'(starts - n), 10'h000);
        @(posedge i_ref_clk) trig <= 7'b0000010;
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'ha0);
        cyc(2);
        n = starts;
        wr(crt_pkg::OFS_TRIG_SELECT, 8'h02);
        cyc(3);
        check("switch edge", 10'(starts - n), 10'h001);
        wait_done();
        n = starts;
        wr(crt_pkg::OFS_TRIG_SELECT, 8'h00);
        cyc(6);
        check("switch free", 10'(starts - n), 10'h000);
        $display("test trigger finished");
    endtask : t_trig

    task automatic t_free();
        int i;
        @(posedge i_ref_clk) trig <= '0;
        n = starts;
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'he0);
        cyc(20);
        check("free restarts", 10'(starts - n >= 2), 10'h001);
        for (i = 0; i < 30 && start !== 1'b1; i++) cyc(1);
        wr(crt_pkg::OFS_CTRL_STAT_A, 8'h00);
        cyc(1);
        check("enable off", {9'h000, core_en}, 10'h000);
        n = starts;
        cyc(15);
        check("stopped", 10'(starts - n), 10'h000);
        rd(crt_pkg::OFS_CTRL_STAT_A, rv);
        check("busy", {9'h000, rv[crt_pkg::CA_START]}, 10'h000);
        $display("test free run finished");
    endtask : t_free

    task automatic t_pins();
        @(posedge i_ref_clk) port_pin <= 8'h5a;
        wr(crt_pkg::OFS_PIN_DISABLE, 8'h0f);
        cyc(2);
        check("buffer off", {2'b00, buf_off}, 10'h00f);
        check("pin in", {2'b00, pin_in}, 10'h050);
        rchk(crt_pkg::OFS_PIN_DISABLE, 8'h0f);
        $display("test pins finished");
    endtask : t_pins

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        // Whole run takes a few hundred cycles; this leaves ample margin
        #(50 * 20000);
        n_fail++;
        conclude();
    end

    initial begin
        bus       = '0;
        trig      = '0;
        vec_ack   = 1'b0;
        port_pin  = 8'h00;
        core_val  = 10'h000;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_result();
        t_lock();
        t_left();
        t_trig();
        t_free();
        t_pins();
        conclude();
    end
endmodule : testbench
